/* rtl/cep_pkg.sv */
// package: encodings, field layouts and reset values for the condition and pointer decode block
`default_nettype none
package cep_pkg;
   localparam int NUM_PTR    = 6;
   localparam int PTR_W      = 16;
   localparam int STEP_W     = 7;
   localparam int MOD_W      = 9;
   localparam int GUARD_W    = 4;
   localparam int WORD_W     = 16;
   localparam int PTR_SEL_W  = 3;
   localparam int SET_SPLIT  = 4;
   localparam logic [PTR_SEL_W-1:0] PTR_ZERO = 3'h0;
   localparam logic [PTR_W-1:0] PTR_RST      = 16'h0000;
   localparam logic [GUARD_W-1:0] GUARD_RST  = 4'h0;

   typedef enum logic [3:0] {
      CEP_C_TRUE, CEP_C_EQ, CEP_C_NEQ, CEP_C_GT, CEP_C_GE, CEP_C_LT, CEP_C_LE, CEP_C_NN,
      CEP_C_V, CEP_C_C, CEP_C_E, CEP_C_L, CEP_C_NR, CEP_C_UI0_LOW, CEP_C_UI0_HIGH, CEP_C_UI1_HIGH
   } cep_cond_t;

   typedef enum logic [1:0] {
      CEP_PM_NONE, CEP_PM_INC, CEP_PM_DEC, CEP_PM_STEP
   } cep_pmod_t;

   typedef enum logic [2:0] {
      CEP_OP_NOP, CEP_OP_MOVH, CEP_OP_RETI, CEP_OP_INDIRECT, CEP_OP_MODR, CEP_OP_NORM, CEP_OP_MAXMIN
   } cep_op_t;

   // status flags feeding condition evaluation
   typedef struct packed {
      logic z;
      logic m;
      logic n;
      logic v;
      logic c;
      logic e;
      logic l;
      logic r;
   } cep_flags_t;

   // one decoded instruction
   typedef struct packed {
      logic                   valid;
      cep_op_t                op;
      logic                   has_cond;
      cep_cond_t              cond;
      logic                   opt_keep_ext;
      logic                   opt_context;
      logic                   opt_dmod;
      logic [PTR_SEL_W-1:0]   ptr_sel;
      cep_pmod_t              pmod;
      logic [WORD_W-1:0]      data;
   } cep_instr_t;

   // one step and modulo setup set
   typedef struct packed {
      logic signed [STEP_W-1:0] step;
      logic [MOD_W-1:0]         modsz;
   } cep_setup_t;
endpackage
`default_nettype wire

/* rtl/cep_ptr_step.sv */
// pointer post-modification arithmetic with optional modulo wrap
`default_nettype none
module cep_ptr_step #(
   parameter int PW = cep_pkg::PTR_W,
   parameter int SW = cep_pkg::STEP_W,
   parameter int MW = cep_pkg::MOD_W
) (
   input  wire logic [PW-1:0]        ptr_in,
   input  wire cep_pkg::cep_pmod_t   pmod,
   input  wire logic signed [SW-1:0] step,
   input  wire logic [MW-1:0]        modsz,
   input  wire logic                 wrap_en,
   output logic [PW-1:0]             ptr_out
);
   logic signed [PW-1:0] delta;
   logic [PW-1:0]        raw;
   logic [PW-1:0]        len;
   logic [PW-1:0]        base;
   logic [PW-1:0]        top;
   always_comb begin
      unique case (pmod)
         cep_pkg::CEP_PM_NONE: delta = '0;
         cep_pkg::CEP_PM_INC:  delta = PW'(1);
         cep_pkg::CEP_PM_DEC:  delta = -PW'(1);
         cep_pkg::CEP_PM_STEP: delta = PW'(step);
      endcase
      raw  = PW'(ptr_in + delta);
      // field value k means buffer length k+1, so 0..511 covers 1..512
      len  = PW'({1'b0, modsz}) + PW'(1);
      // buffers sit on boundaries of the largest modulo length
      base = ptr_in & ~((PW'(1) << MW) - PW'(1));
      top  = PW'(base + len - PW'(1));
      ptr_out = raw;
      if (wrap_en && pmod != cep_pkg::CEP_PM_NONE) begin
         if (!delta[PW-1] && ptr_in <= top && raw > top) begin
            ptr_out = PW'(raw - len);
         end else if (delta[PW-1] && (raw < base || raw > ptr_in)) begin
            ptr_out = PW'(raw + len);
         end
      end
   end
endmodule
`default_nettype wire

/* rtl/cep_decode.sv */
// condition evaluation, option fields and pointer post-modification
// What this block does
// - high-word move keeps guard bits with keep-extension, else sign-extends into them
// - interrupt return with context option restores context; without it, none
// - modulo-disable option turns wrap off on MODR only; otherwise the pointer wrap bit decides
// - always true; zero, nonzero, positive, nonnegative, negative, nonpositive from Z and M
// - single flag tests: N clear, V, C, E, L set, R clear
// - user input pins: input 0 low, input 0 high, input 1 high
// - datapath arithmetic is two's complement
// - post-modify for indirect, step, normalize; search ops only through pointer zero
// - pointer stays, increments, decrements or adds signed step
// - step sizes are 7-bit signed, -64 to 63, in setup registers
// - modulo sizes are 9-bit unsigned, lengths 1 to 512
// - each pointer has its own wrap-enable bit in status word two
// - missing condition field evaluates as always true
`default_nettype none
module cep_decode #(
   parameter int NP = cep_pkg::NUM_PTR
) (
   input  wire logic                    core_clk,
   input  wire logic                    sys_rst,
   input  wire cep_pkg::cep_instr_t     instr,
   input  wire cep_pkg::cep_flags_t     flags,
   input  wire logic                    user_in0,
   input  wire logic                    user_in1,
   input  wire cep_pkg::cep_setup_t     pointer_setup_reg_i,
   input  wire cep_pkg::cep_setup_t     pointer_setup_reg_j,
   input  wire logic [NP-1:0]           status_word_two,
   input  wire logic                    ptr_load,
   input  wire logic [cep_pkg::PTR_SEL_W-1:0] ptr_load_sel,
   input  wire logic [cep_pkg::PTR_W-1:0]     ptr_load_val,
   output logic                         cond_true,
   output logic                         exec_done,
   output logic                         context_restore,
   output logic                         reti_done,
   output logic                         ptr_modified,
   output logic [cep_pkg::PTR_W-1:0]    address_pointer [NP],
   output logic [cep_pkg::WORD_W-1:0]   accum_high,
   output logic [cep_pkg::GUARD_W-1:0]  accum_guard_bits
);
   // ======================================================
   // state
   typedef struct packed {
      logic [2:0]                       ui0_sync;
      logic [2:0]                       ui1_sync;
      logic                             ui0;
      logic                             ui1;
      logic                             cond;
      logic                             done;
      logic                             ctx;
      logic                             reti;
      logic                             pmod;
      logic [NP-1:0][cep_pkg::PTR_W-1:0] ptr;
      logic [cep_pkg::WORD_W-1:0]       ah;
      logic [cep_pkg::GUARD_W-1:0]      ae;
   } cep_state_t;

   cep_state_t st_q;
   cep_state_t st_d;

   function automatic logic eval_cond(input logic has, input cep_pkg::cep_cond_t c,
                                      input cep_pkg::cep_flags_t f, input logic u0, input logic u1);
      logic res;
      res = 1'b1;
      if (has) begin
         unique case (c)
            cep_pkg::CEP_C_TRUE:     res = 1'b1;
            cep_pkg::CEP_C_EQ:       res = f.z;
            cep_pkg::CEP_C_NEQ:      res = !f.z;
            cep_pkg::CEP_C_GT:       res = !f.m && !f.z;
            cep_pkg::CEP_C_GE:       res = !f.m;
            cep_pkg::CEP_C_LT:       res = f.m;
            cep_pkg::CEP_C_LE:       res = f.m || f.z;
            cep_pkg::CEP_C_NN:       res = !f.n;
            cep_pkg::CEP_C_V:        res = f.v;
            cep_pkg::CEP_C_C:        res = f.c;
            cep_pkg::CEP_C_E:        res = f.e;
            cep_pkg::CEP_C_L:        res = f.l;
            cep_pkg::CEP_C_NR:       res = !f.r;
            cep_pkg::CEP_C_UI0_LOW:  res = !u0;
            cep_pkg::CEP_C_UI0_HIGH: res = u0;
            cep_pkg::CEP_C_UI1_HIGH: res = u1;
         endcase
      end
      return res;
   endfunction

   // ======================================================
   // pointer path
   logic                      pm_allowed;
   logic                      sel_ok;
   logic                      wrap_en;
   logic                      ctrue;
   cep_pkg::cep_setup_t       setup;
   logic [cep_pkg::PTR_W-1:0] ptr_cur;
   logic [cep_pkg::PTR_W-1:0] ptr_new;

   always_comb begin
      sel_ok  = int'(instr.ptr_sel) < NP;
      ptr_cur = sel_ok ? st_q.ptr[instr.ptr_sel] : cep_pkg::PTR_RST;
      setup   = (int'(instr.ptr_sel) < cep_pkg::SET_SPLIT) ? pointer_setup_reg_i
                                                            : pointer_setup_reg_j;
      wrap_en = sel_ok && status_word_two[instr.ptr_sel]
                && !(instr.op == cep_pkg::CEP_OP_MODR && instr.opt_dmod);
      unique case (instr.op)
         cep_pkg::CEP_OP_INDIRECT, cep_pkg::CEP_OP_MODR, cep_pkg::CEP_OP_NORM: pm_allowed = sel_ok;
         cep_pkg::CEP_OP_MAXMIN: pm_allowed = instr.ptr_sel == cep_pkg::PTR_ZERO;
         default: pm_allowed = 1'b0;
      endcase
      ctrue = eval_cond(instr.has_cond, instr.cond, flags, st_q.ui0, st_q.ui1);
   end

   cep_ptr_step u_step (
      .ptr_in  (ptr_cur),
      .pmod    (instr.pmod),
      .step    (setup.step),
      .modsz   (setup.modsz),
      .wrap_en (wrap_en),
      .ptr_out (ptr_new)
   );

   // ======================================================
   // next state
   always_comb begin
      st_d = st_q;
      st_d.ui0_sync = {st_q.ui0_sync[1:0], user_in0};
      st_d.ui1_sync = {st_q.ui1_sync[1:0], user_in1};
      if (st_q.ui0_sync[2] == st_q.ui0_sync[1]) begin
         st_d.ui0 = st_q.ui0_sync[2];
      end
      if (st_q.ui1_sync[2] == st_q.ui1_sync[1]) begin
         st_d.ui1 = st_q.ui1_sync[2];
      end
      st_d.cond = ctrue;
      st_d.done = instr.valid;
      st_d.ctx  = 1'b0;
      st_d.reti = 1'b0;
      st_d.pmod = 1'b0;
      if (ptr_load && int'(ptr_load_sel) < NP) begin
         st_d.ptr[ptr_load_sel] = ptr_load_val;
      end
      if (instr.valid && ctrue) begin
         unique case (instr.op)
            cep_pkg::CEP_OP_MOVH: begin
               st_d.ah = instr.data;
               if (!instr.opt_keep_ext) begin
                  st_d.ae = {cep_pkg::GUARD_W{instr.data[cep_pkg::WORD_W-1]}};
               end
            end
            cep_pkg::CEP_OP_RETI: begin
               st_d.reti = 1'b1;
               st_d.ctx  = instr.opt_context;
            end
            default: begin
               if (pm_allowed && instr.pmod != cep_pkg::CEP_PM_NONE) begin
                  st_d.ptr[instr.ptr_sel] = ptr_new;
                  st_d.pmod = 1'b1;
               end
            end
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   // ======================================================
   // outputs
   always_comb begin
      cond_true        = st_q.cond;
      exec_done        = st_q.done;
      context_restore  = st_q.ctx;
      reti_done        = st_q.reti;
      ptr_modified     = st_q.pmod;
      accum_high       = st_q.ah;
      accum_guard_bits = st_q.ae;
      for (int i = 0; i < NP; i++) begin
         address_pointer[i] = st_q.ptr[i];
      end
   end

   // ======================================================
   // checks
   chk_cond_eq: assert property (@(posedge core_clk) disable iff (sys_rst)
      instr.has_cond && instr.cond == cep_pkg::CEP_C_EQ |=> cond_true == $past(flags.z))
      else $error("eq condition mismatch");
   chk_cond_le: assert property (@(posedge core_clk) disable iff (sys_rst)
      instr.has_cond && instr.cond == cep_pkg::CEP_C_LE |=> cond_true == $past(flags.m || flags.z))
      else $error("le condition mismatch");
   chk_cond_nr: assert property (@(posedge core_clk) disable iff (sys_rst)
      instr.has_cond && instr.cond == cep_pkg::CEP_C_NR |=> cond_true == !$past(flags.r))
      else $error("nr condition mismatch");
   chk_user_pin: assert property (@(posedge core_clk) disable iff (sys_rst)
      $rose(user_in0) ##1 user_in0 [*4] |-> st_q.ui0)
      else $error("user pin not seen");
   chk_no_cond: assert property (@(posedge core_clk) disable iff (sys_rst)
      !instr.has_cond |=> cond_true)
      else $error("missing condition not true");
   chk_keep_ext: assert property (@(posedge core_clk) disable iff (sys_rst)
      instr.valid && instr.op == cep_pkg::CEP_OP_MOVH && instr.opt_keep_ext
      |=> $stable(accum_guard_bits))
      else $error("guard bits changed");
   chk_sign_ext: assert property (@(posedge core_clk) disable iff (sys_rst)
      instr.valid && ctrue && instr.op == cep_pkg::CEP_OP_MOVH && !instr.opt_keep_ext
      |=> accum_guard_bits == {cep_pkg::GUARD_W{$past(instr.data[cep_pkg::WORD_W-1])}})
      else $error("guard bits not sign extended");
   chk_reti_ctx: assert property (@(posedge core_clk) disable iff (sys_rst)
      reti_done |-> context_restore == $past(instr.opt_context))
      else $error("context option ignored");
   chk_maxmin_r0: assert property (@(posedge core_clk) disable iff (sys_rst)
      instr.valid && instr.op == cep_pkg::CEP_OP_MAXMIN && instr.ptr_sel != cep_pkg::PTR_ZERO
      |=> !ptr_modified)
      else $error("search op moved non-zero pointer");
   chk_inc_nowrap: assert property (@(posedge core_clk) disable iff (sys_rst)
      instr.valid && ctrue && instr.op == cep_pkg::CEP_OP_MODR && instr.opt_dmod
      && instr.pmod == cep_pkg::CEP_PM_INC && instr.ptr_sel == 3'h1 && !ptr_load
      |=> address_pointer[1] == $past(address_pointer[1]) + 16'h0001)
      else $error("dmod increment wrong");
   cov_reti_ctx: cover property (@(posedge core_clk) context_restore);
   cov_wrap: cover property (@(posedge core_clk) ptr_modified && $past(wrap_en));
   cov_movh: cover property (@(posedge core_clk) instr.valid && instr.op == cep_pkg::CEP_OP_MOVH);
endmodule
`default_nettype wire

/* verif/cond_eval_and_pointer_postmod_test.sv */
// self-checking bench for the condition and pointer decode block
`default_nettype none
module cond_eval_and_pointer_postmod_test;
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================
   // stimulus and observation
   logic                   core_clk = 1'b0;
   logic                   sys_rst  = 1'b1;
   cep_pkg::cep_instr_t    instr    = '0;
   cep_pkg::cep_flags_t    flags    = '0;
   logic                   user_in0 = 1'b0;
   logic                   user_in1 = 1'b0;
   cep_pkg::cep_setup_t    setup_i  = '0;
   cep_pkg::cep_setup_t    setup_j  = '0;
   logic [5:0]             wrap_en  = 6'h00;
   logic                   ptr_load = 1'b0;
   logic [2:0]             ld_sel   = 3'h0;
   logic [15:0]            ld_val   = 16'h0000;
   logic                   cond_true, exec_done, ctx_rst, reti_done, ptr_mod;
   logic [15:0]            ptr [6];
   logic [15:0]            acc_h;
   logic [3:0]             guard;
   int                     errors = 0;
   int                     n_compared = 0;

   always #4 core_clk = ~core_clk;

   cep_decode #(.NP(6)) i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .instr(instr), .flags(flags),
      .user_in0(user_in0), .user_in1(user_in1), .pointer_setup_reg_i(setup_i), .pointer_setup_reg_j(setup_j),
      .status_word_two(wrap_en), .ptr_load(ptr_load), .ptr_load_sel(ld_sel), .ptr_load_val(ld_val),
      .cond_true(cond_true), .exec_done(exec_done), .context_restore(ctx_rst), .reti_done(reti_done),
      .ptr_modified(ptr_mod), .address_pointer(ptr), .accum_high(acc_h), .accum_guard_bits(guard));

   // ==========================================
   // shared tasks
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wrap_up;
      $display("compared %0d, mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // one instruction for one cycle; outputs are settled at the following falling edge
   task automatic go(input cep_pkg::cep_op_t op, input logic [2:0] sel, input cep_pkg::cep_pmod_t pm,
                     input logic [2:0] opts, input logic [15:0] d, input cep_pkg::cep_cond_t c, input logic hc);
      @(negedge core_clk);
      instr <= '{1'b1, op, hc, c, opts[2], opts[1], opts[0], sel, pm, d};
      @(negedge core_clk);
      instr.valid <= 1'b0;
   endtask

   task automatic pm(input cep_pkg::cep_op_t op, input logic [2:0] sel, input cep_pkg::cep_pmod_t m,
                     input logic dm);
      go(op, sel, m, {2'b00, dm}, 16'h0000, cep_pkg::CEP_C_TRUE, 1'b0);
   endtask

   task automatic ld(input logic [2:0] sel, input logic [15:0] v);
      @(negedge core_clk);
      ptr_load <= 1'b1;
      ld_sel   <= sel;
      ld_val   <= v;
      @(negedge core_clk);
      ptr_load <= 1'b0;
   endtask

   function automatic logic cond_exp(input logic [3:0] c, input cep_pkg::cep_flags_t f, input logic u0,
                                     input logic u1);
      case (c)
         4'h0: return 1'b1;
         4'h1: return f.z;
         4'h2: return !f.z;
         4'h3: return !f.m && !f.z;
         4'h4: return !f.m;
         4'h5: return f.m;
         4'h6: return f.m || f.z;
         4'h7: return !f.n;
         4'h8: return f.v;
         4'h9: return f.c;
         4'ha: return f.e;
         4'hb: return f.l;
         4'hc: return !f.r;
         4'hd: return !u0;
         4'he: return u0;
         default: return u1;
      endcase
   endfunction

   // ==========================================
   // scenarios
   task automatic t_cond;
      for (int p = 0; p < 2; p++) begin
         @(negedge core_clk);
         flags    <= cep_pkg::cep_flags_t'(p ? 8'h3f : 8'hc0);
         user_in0 <= p[0];
         user_in1 <= !p[0];
         repeat (6) @(negedge core_clk);
         for (int c = 0; c < 16; c++) begin
            go(cep_pkg::CEP_OP_NOP, 3'h0, cep_pkg::CEP_PM_NONE, 3'h0, 16'h0000, cep_pkg::cep_cond_t'(c), 1'b1);
            chk("cond", {15'h0, cond_true}, {15'h0, cond_exp(c[3:0], flags, user_in0, user_in1)});
         end
      end
      go(cep_pkg::CEP_OP_NOP, 3'h0, cep_pkg::CEP_PM_NONE, 3'h0, 16'h0000, cep_pkg::CEP_C_EQ, 1'b0);
      chk("cond omitted", {15'h0, cond_true}, 16'h0001);
      ld(3'h0, 16'h0010);
      go(cep_pkg::CEP_OP_MODR, 3'h0, cep_pkg::CEP_PM_INC, 3'h0, 16'h0000, cep_pkg::CEP_C_EQ, 1'b1);
      chk("false cond exec", {15'h0, exec_done}, 16'h0001);
      chk("false cond ptr", ptr[0], 16'h0010);
   endtask

   task automatic t_opts;
      go(cep_pkg::CEP_OP_MOVH, 3'h0, cep_pkg::CEP_PM_NONE, 3'h0, 16'h8000, cep_pkg::CEP_C_TRUE, 1'b0);
      chk("guard sext", {12'h0, guard}, 16'h000f);
      go(cep_pkg::CEP_OP_MOVH, 3'h0, cep_pkg::CEP_PM_NONE, 3'h4, 16'h1234, cep_pkg::CEP_C_TRUE, 1'b0);
      chk("guard kept", {12'h0, guard}, 16'h000f);
      chk("acc high", acc_h, 16'h1234);
      go(cep_pkg::CEP_OP_MOVH, 3'h0, cep_pkg::CEP_PM_NONE, 3'h0, 16'h1234, cep_pkg::CEP_C_TRUE, 1'b0);
      chk("guard pos", {12'h0, guard}, 16'h0000);
      for (int k = 0; k < 2; k++) begin
         go(cep_pkg::CEP_OP_RETI, 3'h0, cep_pkg::CEP_PM_NONE, {1'b0, k[0], 1'b0}, 16'h0000,
            cep_pkg::CEP_C_TRUE, 1'b1);
         chk("ctx", {15'h0, ctx_rst}, {15'h0, k[0]});
         chk("reti", {15'h0, reti_done}, 16'h0001);
      end
   endtask

   task automatic t_step;
      setup_i <= '{7'h40, 9'h003};
      setup_j <= '{7'h3f, 9'h003};
      pm(cep_pkg::CEP_OP_MODR, 3'h0, cep_pkg::CEP_PM_INC, 1'b0);
      chk("inc", ptr[0], 16'h0011);
      pm(cep_pkg::CEP_OP_MODR, 3'h0, cep_pkg::CEP_PM_DEC, 1'b0);
      chk("dec", ptr[0], 16'h0010);
      pm(cep_pkg::CEP_OP_MODR, 3'h0, cep_pkg::CEP_PM_STEP, 1'b0);
      chk("step -64", ptr[0], 16'hffd0);
      pm(cep_pkg::CEP_OP_MODR, 3'h0, cep_pkg::CEP_PM_NONE, 1'b0);
      chk("none", ptr[0], 16'hffd0);
      ld(3'h4, 16'h0100);
      pm(cep_pkg::CEP_OP_MODR, 3'h4, cep_pkg::CEP_PM_STEP, 1'b0);
      chk("set j step", ptr[4], 16'h013f);
      wrap_en <= 6'h02;
      ld(3'h1, 16'h0203);
      pm(cep_pkg::CEP_OP_MODR, 3'h1, cep_pkg::CEP_PM_INC, 1'b0);
      chk("wrap top", ptr[1], 16'h0200);
      pm(cep_pkg::CEP_OP_MODR, 3'h1, cep_pkg::CEP_PM_DEC, 1'b0);
      chk("wrap base", ptr[1], 16'h0203);
      pm(cep_pkg::CEP_OP_MODR, 3'h1, cep_pkg::CEP_PM_INC, 1'b1);
      chk("dmod", ptr[1], 16'h0204);
      setup_i.modsz <= 9'h1ff;
      ld(3'h1, 16'h03ff);
      pm(cep_pkg::CEP_OP_MODR, 3'h1, cep_pkg::CEP_PM_INC, 1'b0);
      chk("len 512", ptr[1], 16'h0200);
      wrap_en <= 6'h00;
      ld(3'h1, 16'h03ff);
      pm(cep_pkg::CEP_OP_MODR, 3'h1, cep_pkg::CEP_PM_INC, 1'b0);
      chk("wrap off", ptr[1], 16'h0400);
   endtask

   task automatic t_ops;
      ld(3'h2, 16'h0050);
      pm(cep_pkg::CEP_OP_MAXMIN, 3'h2, cep_pkg::CEP_PM_INC, 1'b0);
      chk("search r2", ptr[2], 16'h0050);
      chk("search r2 mod", {15'h0, ptr_mod}, 16'h0000);
      pm(cep_pkg::CEP_OP_MAXMIN, 3'h0, cep_pkg::CEP_PM_INC, 1'b0);
      chk("search r0 mod", {15'h0, ptr_mod}, 16'h0001);
      pm(cep_pkg::CEP_OP_NORM, 3'h2, cep_pkg::CEP_PM_INC, 1'b0);
      chk("norm", ptr[2], 16'h0051);
      pm(cep_pkg::CEP_OP_INDIRECT, 3'h2, cep_pkg::CEP_PM_DEC, 1'b0);
      chk("indirect", ptr[2], 16'h0050);
      pm(cep_pkg::CEP_OP_MODR, 3'h6, cep_pkg::CEP_PM_INC, 1'b0);
      chk("sel 6 mod", {15'h0, ptr_mod}, 16'h0000);
   endtask

   // ==========================================
   // main sequence and watchdog
   initial begin
      repeat (16) @(negedge core_clk);
      sys_rst <= 1'b0;
      chk("rst ptr", ptr[0], 16'h0000);
      chk("rst guard", {12'h0, guard}, 16'h0000);
      t_cond();
      t_opts();
      t_step();
      t_ops();
      wrap_up();
   end

   initial begin
      #20000;
      errors++;
      wrap_up();
   end
endmodule
`default_nettype wire
